// File: design/eag_pkg.sv
package eag_pkg;

    // Instruction word, documented bit n sits at vector bit (31 - n)
    localparam int INSTR_W         = 32;
    localparam int IR_W            = 34;
    localparam int IND_BIT         = 31;
    localparam int X_HI            = 19;
    localparam int X_LO            = 17;
    localparam int M_HI            = 16;
    localparam int IMM_HI          = 19;
    localparam int IMM_W           = 20;
    localparam int EXT_SEL_BIT     = 16;
    localparam int REGION_HI       = 15;
    localparam int FULL_ADDR_HI    = 21;

    // Address widths
    localparam int WADDR_W         = 22;
    localparam int NORM_WADDR_W    = 17;
    localparam int BADDR_W         = 24;
    localparam int NORM_BADDR_W    = 19;
    localparam int EXT_ADDR_W      = 6;
    localparam int REGION_W        = 16;

    // Register file
    localparam int REG_NUM_W       = 4;
    localparam int REG_PTR_W       = 4;
    localparam int REG_SEL_W       = REG_PTR_W + REG_NUM_W;
    localparam int X_W             = 3;
    localparam logic [WADDR_W-1:0] REG_RANGE_TOP = 22'h00000F;

    // Program status doubleword field positions, bit n at vector bit (63 - n)
    localparam int SDW_W           = 64;
    localparam int SDW_MAP_BIT     = 54;
    localparam int SDW_MA_BIT      = 23;
    localparam int SDW_EXT_HI      = 21;
    localparam int SDW_EXT_LO      = 16;
    localparam int SDW_RP_HI       = 35;
    localparam int SDW_RP_LO       = 32;

    typedef enum logic [1:0] {
        EAG_SZ_BYTE,
        EAG_SZ_HALF,
        EAG_SZ_WORD,
        EAG_SZ_DOUBLE
    } eag_size_t;

endpackage

// File: design/eag_index_align.sv
module eag_index_align
    import eag_pkg::*;
(
    // Operands
    input  wire logic [BADDR_W-1:0] base_byte,
    input  wire logic [31:0]        disp,
    input  wire eag_size_t          size,
    input  wire logic               ext_mode,
    // Result
    output logic      [BADDR_W-1:0] sum
);

    logic [BADDR_W-1:0] disp_low;
    logic [BADDR_W-1:0] shifted;
    logic [BADDR_W-1:0] raw;

    // Upper displacement bits never reach the adder
    assign disp_low = disp[BADDR_W-1:0];                                 // see RULE8
    assign shifted  = disp_low << size;                                  // see RULE6
    assign raw      = base_byte + shifted;

    // Normal mode delivers only 19 bits; upper five read as zero
    always_comb begin
        if (ext_mode) begin
            sum = raw;                                                   // see RULE7
        end else begin
            sum = {{(BADDR_W-NORM_BADDR_W){1'b0}}, raw[NORM_BADDR_W-1:0]}; // see RULE7
        end
    end

endmodule

// File: design/eag_core.sv
// What this block does
// RULE1: Addresses 0 to 15 select a current-block register; no memory cycle issued.
// RULE2: Immediate opcodes take the operand from instruction bits 12 to 31.
// RULE3: Immediate operands ignore the indirect flag and the index field.
// RULE4: Nonzero index field bits 12-14 selects the displacement register.
// RULE5: Instruction held in 34-bit register with two low zero bits.
// RULE6: Displacement shifted left 0 to 3 by operand size before addition.
// RULE7: Result is 19 bits normally, 24 bits in real extended mode.
// RULE8: Displacement bits above final address width are discarded.
// RULE9: Instruction bit 0 set reads the indirect word at the word address.
// RULE10: Indirect without indexing uses the indirect address unchanged.
// RULE11: With both, indirect address replaces the field, then indexing applies.
// RULE12: Extended mode, indirect bit 0 clear gives 22-bit address from bits 10-31.
// RULE13: Extended mode, indirect bit 0 set: selector bit 15, region bits 16-31.
// RULE14: Clear selector gives region zero; set selector prefixes the extension address.
// RULE15: Real extended mode is map indicator clear and mode-altered set.
// RULE16: Extension address comes from status doubleword bits 42 to 47.
// RULE17: Current register block comes from the status doubleword register pointer.
// RULE18: A qualifier says whether the result targets registers or memory.
module eag_core
    import eag_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Request from the sequencer
    input  wire logic                 start,
    input  wire logic [INSTR_W-1:0]   instr,
    input  wire logic                 imm_op,
    input  wire eag_size_t            op_size,
    input  wire logic [SDW_W-1:0]     program_status_doubleword,
    output logic                      busy,
    // Main memory read port for indirect words
    output logic                      mem_rd_req,
    output logic      [WADDR_W-1:0]   mem_rd_addr,
    input  wire logic                 mem_rd_ack,
    input  wire logic [INSTR_W-1:0]   mem_rd_data,
    // Register file read port, data one cycle after request
    output logic                      reg_rd_req,
    output logic      [REG_SEL_W-1:0] reg_rd_sel,
    input  wire logic [31:0]          reg_rd_data,
    // Result
    output logic                      ea_valid,
    output logic                      ea_is_reg,
    output logic      [REG_SEL_W-1:0] ea_reg_sel,
    output logic      [BADDR_W-1:0]   ea_byte_addr,
    output logic                      ea_imm_valid,
    output logic      [IMM_W-1:0]     ea_imm
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_IND_MEM,
        S_IND_REG_REQ,
        S_IND_REG_GET,
        S_IDX_REQ,
        S_IDX_GET,
        S_DONE
    } eag_state_t;

    eag_state_t           state_reg,    state_next;
    logic [IR_W-1:0]      ir_reg,       ir_next;
    logic [WADDR_W-1:0]   waddr_reg,    waddr_next;
    logic                 ext_reg,      ext_next;
    eag_size_t            size_reg,     size_next;
    logic [REG_PTR_W-1:0] ptr_reg,      ptr_next;
    logic [EXT_ADDR_W-1:0] xaddr_reg,   xaddr_next;
    logic                 isreg_reg,    isreg_next;
    logic [REG_SEL_W-1:0] rsel_reg,     rsel_next;
    logic [BADDR_W-1:0]   baddr_reg,    baddr_next;
    logic                 imm_reg,      imm_next;
    logic [IMM_W-1:0]     immv_reg,     immv_next;

    logic                 in_ext;
    logic [EXT_ADDR_W-1:0] in_xaddr;
    logic [WADDR_W-1:0]   first_level;
    logic [X_W-1:0]       x_field;
    logic [WADDR_W-1:0]   ind_addr;
    logic [INSTR_W-1:0]   ind_word;
    logic [BADDR_W-1:0]   idx_sum;
    logic [BADDR_W-1:0]   base_byte;

    // Real extended mode qualifier taken from the live status doubleword
    assign in_ext   = ~program_status_doubleword[SDW_MAP_BIT]
                    &  program_status_doubleword[SDW_MA_BIT];            // see RULE15
    assign in_xaddr = program_status_doubleword[SDW_EXT_HI:SDW_EXT_LO];  // see RULE16

    // A 17-bit address: in extended mode bit 15 picks region 0 or the program region
    function automatic logic [WADDR_W-1:0] fold17(input logic [NORM_WADDR_W-1:0] a,
                                                   input logic ext,
                                                   input logic [EXT_ADDR_W-1:0] xa);
        logic [WADDR_W-1:0] r;
        r = {{(WADDR_W-NORM_WADDR_W){1'b0}}, a};
        if (ext) begin
            if (a[EXT_SEL_BIT]) begin
                r = {xa, a[REGION_HI:0]};                                // see RULE14
            end else begin
                r = {{EXT_ADDR_W{1'b0}}, a[REGION_HI:0]};                // see RULE14
            end
        end
        return r;
    endfunction

    assign first_level = fold17(instr[M_HI:0], in_ext, in_xaddr);
    assign x_field     = ir_reg[X_HI+2:X_LO+2];

    // Indirect word comes from memory, or from a register in the register range
    assign ind_word = (state_reg == S_IND_MEM) ? mem_rd_data : reg_rd_data;

    always_comb begin
        ind_addr = fold17(ind_word[M_HI:0], ext_reg, xaddr_reg);         // see RULE13
        if (ext_reg && !ind_word[IND_BIT]) begin
            ind_addr = ind_word[FULL_ADDR_HI:0];                         // see RULE12
        end
    end

    assign base_byte = {waddr_reg, 2'b00};

    eag_index_align u_align (
        .base_byte (base_byte),
        .disp      (reg_rd_data),
        .size      (size_reg),
        .ext_mode  (ext_reg),
        .sum       (idx_sum)
    );

    always_comb begin
        state_next = state_reg;
        ir_next    = ir_reg;
        waddr_next = waddr_reg;
        ext_next   = ext_reg;
        size_next  = size_reg;
        ptr_next   = ptr_reg;
        xaddr_next = xaddr_reg;
        isreg_next = isreg_reg;
        rsel_next  = rsel_reg;
        baddr_next = baddr_reg;
        imm_next   = imm_reg;
        immv_next  = immv_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (start) begin
                    ir_next    = {instr, 2'b00};                         // see RULE5
                    waddr_next = first_level;
                    ext_next   = in_ext;
                    size_next  = op_size;
                    ptr_next   = program_status_doubleword[SDW_RP_HI:SDW_RP_LO]; // see RULE17
                    xaddr_next = in_xaddr;
                    if (imm_op) begin
                        // Indirect flag and index field play no part here
                        imm_next   = 1'b1;                               // see RULE3
                        immv_next  = instr[IMM_HI:0];                    // see RULE2
                        isreg_next = 1'b0;
                        baddr_next = '0;
                        state_next = S_DONE;
                    end else begin
                        imm_next = 1'b0;
                        if (instr[IND_BIT]) begin                        // see RULE9
                            state_next = (first_level <= REG_RANGE_TOP) ? S_IND_REG_REQ
                                                                        : S_IND_MEM; // see RULE1
                        end else if (instr[X_HI:X_LO] != '0) begin       // see RULE4
                            state_next = S_IDX_REQ;
                        end else begin
                            isreg_next = (first_level <= REG_RANGE_TOP); // see RULE1
                            rsel_next  = {program_status_doubleword[SDW_RP_HI:SDW_RP_LO],
                                          first_level[REG_NUM_W-1:0]};
                            baddr_next = {first_level, 2'b00};
                            state_next = S_DONE;
                        end
                    end
                end
            end
            S_IND_MEM, S_IND_REG_GET: begin
                if (state_reg == S_IND_REG_GET || mem_rd_ack) begin
                    // Indirect address replaces the address field first
                    waddr_next = ind_addr;                               // see RULE11
                    ir_next    = {ir_reg[IR_W-1:NORM_BADDR_W], ind_addr[M_HI:0], 2'b00};
                    if (x_field != '0) begin                             // see RULE4
                        state_next = S_IDX_REQ;
                    end else begin
                        isreg_next = (ind_addr <= REG_RANGE_TOP);        // see RULE1
                        rsel_next  = {ptr_reg, ind_addr[REG_NUM_W-1:0]};
                        baddr_next = {ind_addr, 2'b00};                  // see RULE10
                        state_next = S_DONE;
                    end
                end
            end
            S_IND_REG_REQ: begin
                state_next = S_IND_REG_GET;
            end
            S_IDX_REQ: begin
                state_next = S_IDX_GET;
            end
            S_IDX_GET: begin
                // Register range is judged on the final word address
                isreg_next = (idx_sum[BADDR_W-1:2] <= REG_RANGE_TOP);   // see RULE1
                rsel_next  = {ptr_reg, idx_sum[REG_NUM_W+1:2]};
                baddr_next = idx_sum;                                    // see RULE11
                state_next = S_DONE;
            end
            S_DONE: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            ir_reg    <= '0;
            waddr_reg <= '0;
            ext_reg   <= 1'b0;
            size_reg  <= EAG_SZ_BYTE;
            ptr_reg   <= '0;
            xaddr_reg <= '0;
            isreg_reg <= 1'b0;
            rsel_reg  <= '0;
            baddr_reg <= '0;
            imm_reg   <= 1'b0;
            immv_reg  <= '0;
        end else begin
            state_reg <= state_next;
            ir_reg    <= ir_next;
            waddr_reg <= waddr_next;
            ext_reg   <= ext_next;
            size_reg  <= size_next;
            ptr_reg   <= ptr_next;
            xaddr_reg <= xaddr_next;
            isreg_reg <= isreg_next;
            rsel_reg  <= rsel_next;
            baddr_reg <= baddr_next;
            imm_reg   <= imm_next;
            immv_reg  <= immv_next;
        end
    end

    // Handshake outputs decoded from state
    assign busy        = (state_reg != S_IDLE);
    assign mem_rd_req  = (state_reg == S_IND_MEM);
    assign mem_rd_addr = waddr_reg;
    assign reg_rd_req  = (state_reg == S_IND_REG_REQ) || (state_reg == S_IDX_REQ);
    // Index register number is the 3-bit field with a zero on top
    assign reg_rd_sel  = (state_reg == S_IDX_REQ)
                       ? {ptr_reg, 1'b0, x_field}                        // see RULE4
                       : {ptr_reg, waddr_reg[REG_NUM_W-1:0]};            // see RULE17

    assign ea_valid     = (state_reg == S_DONE);
    assign ea_is_reg    = isreg_reg;                                     // see RULE18
    assign ea_reg_sel   = rsel_reg;
    assign ea_byte_addr = baddr_reg;
    assign ea_imm_valid = (state_reg == S_DONE) && imm_reg;
    assign ea_imm       = immv_reg;

endmodule

// File: tb/eag_core_assertions.sv
module eag_core_assertions
    import eag_pkg::*;
(
    // Request
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire logic                 start,
    input wire logic [INSTR_W-1:0]   instr,
    input wire logic                 imm_op,
    input wire logic [SDW_W-1:0]     program_status_doubleword,
    input wire logic                 busy,
    // Far side
    input wire logic                 mem_rd_req,
    input wire logic [WADDR_W-1:0]   mem_rd_addr,
    input wire logic                 mem_rd_ack,
    input wire logic [INSTR_W-1:0]   mem_rd_data,
    input wire logic                 reg_rd_req,
    input wire logic [REG_SEL_W-1:0] reg_rd_sel,
    // Result
    input wire logic                 ea_valid,
    input wire logic                 ea_is_reg,
    input wire logic [REG_SEL_W-1:0] ea_reg_sel,
    input wire logic [BADDR_W-1:0]   ea_byte_addr,
    input wire logic [IMM_W-1:0]     ea_imm
);
    logic            ext_q;
    logic            plain_q;
    wire logic       take = start && !busy && !imm_op;
    wire logic [3:0] rp = program_status_doubleword[SDW_RP_HI:SDW_RP_LO];
    wire logic       ext_now = !program_status_doubleword[SDW_MAP_BIT]
                               && program_status_doubleword[SDW_MA_BIT];

    // Mode and kind of the operation in flight, frozen at the taking edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_q   <= 1'b0;
            plain_q <= 1'b0;
        end else if (start && !busy) begin
            ext_q   <= ext_now;
            plain_q <= !imm_op && instr[IND_BIT] && instr[X_HI:X_LO] == 3'h0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence word_s;
        mem_rd_req && mem_rd_ack && plain_q;
    endsequence
    sequence norm_word_s;
        word_s ##0 (!ext_q && mem_rd_data[16:4] != 13'h0);
    endsequence
    sequence full_word_s;
        word_s ##0 (ext_q && !mem_rd_data[31] && mem_rd_data[21:4] != 18'h0);
    endsequence

    imm_value_a: assert property (start && !busy && imm_op |=> ea_valid && !ea_is_reg
        && ea_imm == $past(instr[IMM_HI:0]) && !mem_rd_req && !reg_rd_req) else $error("imm bad");
    reg_direct_a: assert property (take && !ext_now && !instr[IND_BIT] && instr[X_HI:4] == 16'h0
        |=> ea_valid && ea_is_reg && ea_reg_sel == {$past(rp), $past(instr[3:0])}) else $error("reg bad");
    idx_fetch_a: assert property (take && !instr[IND_BIT] && instr[X_HI:X_LO] != 3'h0
        |=> reg_rd_req && reg_rd_sel == {$past(rp), 1'b0, $past(instr[X_HI:X_LO])}) else $error("idx bad");
    ind_fetch_a: assert property (take && !ext_now && instr[IND_BIT] && instr[M_HI:4] != 13'h0
        |=> mem_rd_req && mem_rd_addr == {5'h00, $past(instr[M_HI:0])}) else $error("ind addr bad");
    req_hold_a: assert property (mem_rd_req && !mem_rd_ack
        |=> mem_rd_req && $stable(mem_rd_addr)) else $error("req dropped");
    ind_plain_a: assert property (norm_word_s |=> ea_valid && !ea_is_reg
        && ea_byte_addr == {5'h00, $past(mem_rd_data[16:0]), 2'b00}) else $error("ind ea bad");
    ind_full_a: assert property (full_word_s |=> ea_valid
        && ea_byte_addr == {$past(mem_rd_data[21:0]), 2'b00}) else $error("full ea bad");
    norm_width_a: assert property (ea_valid && !ea_is_reg && !ext_q
        |-> ea_byte_addr[23:19] == 5'h00) else $error("width bad");
endmodule

bind eag_core eag_core_assertions i_chk (.clk(clk), .arst_n(arst_n), .start(start), .instr(instr),
    .imm_op(imm_op), .program_status_doubleword(program_status_doubleword), .busy(busy),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .reg_rd_req(reg_rd_req), .reg_rd_sel(reg_rd_sel),
    .ea_valid(ea_valid), .ea_is_reg(ea_is_reg), .ea_reg_sel(ea_reg_sel),
    .ea_byte_addr(ea_byte_addr), .ea_imm(ea_imm));

// File: tb/eag_mem_model.sv
module eag_mem_model
    import eag_pkg::*;
(
    // Clock and ack delay
    input  wire logic                 clk,
    input  wire logic [3:0]           ack_delay,
    // Memory and register file ports
    input  wire logic                 mem_rd_req,
    input  wire logic [WADDR_W-1:0]   mem_rd_addr,
    output logic                      mem_rd_ack = 1'b0,
    output logic      [INSTR_W-1:0]   mem_rd_data = '0,
    input  wire logic                 reg_rd_req,
    input  wire logic [REG_SEL_W-1:0] reg_rd_sel,
    output logic      [31:0]          reg_rd_data = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [WADDR_W-1:0]];
    logic [31:0] regs [256];
    logic [3:0]  cnt = 4'h0;

    // Stale data flips every cycle so a late sample never matches
    always @(posedge clk) begin
        reg_rd_data <= #1 reg_rd_req ? regs[reg_rd_sel] : ~reg_rd_data;
        if (mem_rd_req && !mem_rd_ack && cnt == ack_delay) begin
            mem_rd_ack  <= #1 1'b1;
            mem_rd_data <= #1 mem[mem_rd_addr];
        end else begin
            mem_rd_ack  <= #1 1'b0;
            mem_rd_data <= #1 ~mem_rd_data;
        end
        if (mem_rd_req && !mem_rd_ack) begin
            cnt <= (cnt == ack_delay) ? 4'h0 : cnt + 4'h1;
        end
    end
endmodule

// File: tb/effective_address_generator_tb.sv
module effective_address_generator_tb
    import eag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0, arst_n = 1'b0, start = 1'b0, imm_op = 1'b0;
    logic [INSTR_W-1:0]   instr = '0;
    eag_size_t            op_size = EAG_SZ_BYTE;
    logic [SDW_W-1:0]     sdw = '0;
    logic [3:0]           dly = 4'h0;
    logic                 busy, mem_rd_req, mem_rd_ack, reg_rd_req, ea_valid, ea_is_reg, ea_imm_valid;
    logic [WADDR_W-1:0]   mem_rd_addr;
    logic [INSTR_W-1:0]   mem_rd_data;
    logic [31:0]          reg_rd_data;
    logic [REG_SEL_W-1:0] reg_rd_sel, ea_reg_sel;
    logic [BADDR_W-1:0]   ea_byte_addr;
    logic [IMM_W-1:0]     ea_imm;
    int                   error_cnt = 0, check_count = 0, mem_cyc = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (mem_rd_req === 1'b1) mem_cyc <= mem_cyc + 1;

    eag_core i_dut (.clk(clk), .arst_n(arst_n), .start(start), .instr(instr), .imm_op(imm_op),
        .op_size(op_size), .program_status_doubleword(sdw), .busy(busy), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
        .reg_rd_req(reg_rd_req), .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data),
        .ea_valid(ea_valid), .ea_is_reg(ea_is_reg), .ea_reg_sel(ea_reg_sel),
        .ea_byte_addr(ea_byte_addr), .ea_imm_valid(ea_imm_valid), .ea_imm(ea_imm));
    eag_mem_model i_mem (.clk(clk), .ack_delay(dly), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
        .reg_rd_req(reg_rd_req), .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data));

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Opcode and R bits carry noise that must not matter
    function automatic logic [31:0] iw(input logic ind, input logic [2:0] x, input logic [16:0] m);
        return {ind, 11'h5A3, x, m};
    endfunction

    function automatic logic [63:0] pw(input logic map, input logic ext, input logic [5:0] xa);
        logic [63:0] p;
        p = 64'h0;
        p[SDW_MAP_BIT] = map;
        p[SDW_MA_BIT] = ext;
        p[SDW_EXT_HI:SDW_EXT_LO] = xa;
        p[SDW_RP_HI:SDW_RP_LO] = 4'h2;
        return p;
    endfunction

    task automatic run(input logic [31:0] ins, input logic imm, input eag_size_t sz,
                       input logic [63:0] p);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        start = 1'b1;
        instr = ins;
        imm_op = imm;
        op_size = sz;
        sdw = p;
        @(posedge clk);
        #1;
        start = 1'b0;
        while (ea_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(ea_valid, "no result");
    endtask

    task automatic t_imm();
        int m0;
        m0 = mem_cyc;
        run(iw(1'b1, 3'h5, 17'h1ABCD), 1'b1, EAG_SZ_WORD, pw(1'b0, 1'b0, 6'h0));
        chk(ea_imm_valid === 1'b1 && ea_imm === 20'hBABCD, "immediate value");
        chk(mem_cyc == m0 && ea_is_reg === 1'b0, "immediate modified");
    endtask

    task automatic t_reg();
        logic [16:0] a [3] = '{17'h0, 17'hF, 17'h10};
        foreach (a[i]) begin
            run(iw(1'b0, 3'h0, a[i]), 1'b0, EAG_SZ_WORD, pw(i == 2, i == 1, 6'h3F));
            chk(ea_is_reg === (i < 2), "register qualifier");
            if (i < 2) chk(ea_reg_sel === {4'h2, a[i][3:0]}, "register select");
            else chk(ea_byte_addr === 24'h40, "mapped mode address");
        end
    endtask

    task automatic t_idx();
        logic [31:0] d;
        logic [23:0] e;
        d = 32'hFFC0_1003;
        i_mem.regs[8'h23] = d;
        for (int s = 0; s < 8; s++) begin
            run(iw(1'b0, 3'h3, 17'h1FF00), 1'b0, eag_size_t'(s[1:0]), pw(1'b0, s[2], 6'h2A));
            e = (s[2] ? {6'h2A, 16'hFF00, 2'b00} : {5'h0, 17'h1FF00, 2'b00}) + 24'(d << s[1:0]);
            if (!s[2]) e[23:19] = 5'h0;
            chk(ea_byte_addr === e && ea_is_reg === 1'b0, "indexed address");
        end
    endtask

    task automatic t_ind();
        int m0;
        dly = 4'h3;
        i_mem.mem[22'h123] = 32'hFFF1_0456;
        i_mem.regs[8'h21] = 32'h0000_0007;
        i_mem.regs[8'h24] = 32'h0000_0200;
        run(iw(1'b1, 3'h0, 17'h123), 1'b0, EAG_SZ_WORD, pw(1'b0, 1'b0, 6'h0));
        chk(ea_byte_addr === 24'h041158, "indirect address");
        run(iw(1'b1, 3'h1, 17'h123), 1'b0, EAG_SZ_HALF, pw(1'b0, 1'b0, 6'h0));
        chk(ea_byte_addr === 24'h041166, "post-indexed address");
        m0 = mem_cyc;
        run(iw(1'b1, 3'h0, 17'h4), 1'b0, EAG_SZ_WORD, pw(1'b0, 1'b0, 6'h0));
        chk(ea_byte_addr === 24'h000800 && mem_cyc == m0, "indirect via register");
    endtask

    // Start held high while busy must not disturb the operation in flight
    task automatic t_busy();
        int n;
        n = 0;
        dly = 4'h3;
        @(posedge clk);
        #1;
        start = 1'b1;
        instr = iw(1'b1, 3'h0, 17'h123);
        imm_op = 1'b0;
        op_size = EAG_SZ_WORD;
        sdw = pw(1'b0, 1'b0, 6'h0);
        @(posedge clk);
        #1;
        instr = iw(1'b0, 3'h0, 17'h5);
        imm_op = 1'b1;
        chk(busy === 1'b1, "busy after take");
        repeat (2) @(posedge clk);
        #1;
        start = 1'b0;
        while (ea_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(ea_valid === 1'b1 && ea_imm_valid === 1'b0, "start while busy");
        chk(ea_byte_addr === 24'h041158 && ea_is_reg === 1'b0, "busy result");
    endtask

    task automatic t_ext();
        logic [31:0] w [3] = '{32'h7FD2_3456, 32'hC0A0_BEEF, 32'h8001_BEEF};
        logic [23:0] e [3] = '{24'h48D158, 24'h02FBBC, 24'hAAFBBC};
        dly = 4'h0;
        foreach (w[i]) begin
            i_mem.mem[22'h200] = w[i];
            run(iw(1'b1, 3'h0, 17'h00200), 1'b0, EAG_SZ_WORD, pw(1'b0, 1'b1, 6'h2A));
            chk(ea_byte_addr === e[i], "extended indirect");
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_imm();
        t_reg();
        t_idx();
        t_ind();
        t_busy();
        t_ext();
        results();
    end

    initial begin
        #100us;
        error_cnt++;
        results();
    end
endmodule
